/* File: verilog/oag_core.v */
// Notes on behaviour
// - 28A0h: accumulate shifted, pointer plus one
// - 28ABh: plus one, then select pointer three
// - 28D0h: access, then pointer minus index
// - 28E0h: access, then pointer plus index
// - 28C0h: access, pointer minus index, reversed carry
// - 28F0h: access, pointer plus index, reversed carry
// - Repeated reversed adds walk bit-reversed order
// - Low four pointer bits hold reversed step
// - Short 8-bit and long 16-bit constants
// - Short add: low byte added to accumulator
// - Long add: second word added to accumulator
// - Dual access: push prefetch, load immediate
// - Operand moved over program bus at prefetch
// - Finish: pop prefetch, program counter plus two
// - Repeats advance the prefetch counter each time
// - Destination direct: page plus seven-bit offset
// - Low three bits select next pointer
// - Old pointer select saved on reload
`timescale 1ns/1ns
`include "oag_consts.vh"

module oag_core
(
  input  wire                   sys_clk,
  input  wire                   rstn,
  input  wire                   instr_valid,
  input  wire [1:0]             instr_kind,
  input  wire [`OAG_WORD_W-1:0] instr_word,
  input  wire [`OAG_WORD_W-1:0] second_word,
  input  wire [`OAG_RPT_W-1:0]  repeat_count,
  input  wire [`OAG_PAGE_W-1:0] data_page,
  input  wire [`OAG_WORD_W-1:0] mem_rdata,
  input  wire [`OAG_WORD_W-1:0] prog_rdata,
  input  wire                   aux_load,
  input  wire [2:0]             aux_load_sel,
  input  wire [`OAG_WORD_W-1:0] aux_load_data,
  input  wire                   index_load,
  input  wire [`OAG_WORD_W-1:0] index_load_data,
  output wire                   instr_ready,
  output wire [`OAG_WORD_W-1:0] data_addr,
  output wire                   data_rd,
  output wire                   data_wr,
  output wire [`OAG_WORD_W-1:0] data_wdata,
  output wire [`OAG_WORD_W-1:0] program_addr_bus,
  output wire                   prog_rd,
  output wire [`OAG_WORD_W-1:0] program_counter,
  output wire [`OAG_WORD_W-1:0] prefetch_counter,
  output wire [`OAG_WORD_W-1:0] micro_call_stack,
  output wire [`OAG_ACC_W-1:0]  accumulator,
  output wire [2:0]             pointer_select,
  output wire [2:0]             pointer_select_backup,
  output wire [`OAG_WORD_W-1:0] index_value
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [5:0] S_IDLE  = 6'h01;
  localparam [5:0] S_MWAIT = 6'h02;
  localparam [5:0] S_MACC  = 6'h04;
  localparam [5:0] S_FETCH = 6'h08;
  localparam [5:0] S_PWAIT = 6'h10;
  localparam [5:0] S_WRITE = 6'h20;

  // ----------------------------------------------------------------
  // Decode functions
  // ----------------------------------------------------------------
  function op_modifies;
    input [2:0] op;
    begin
      op_modifies = (op != `OAG_OP_NONE) && (op != `OAG_OP_RSVD);
    end
  endfunction

  function op_subtracts;
    input [2:0] op;
    begin
      op_subtracts = (op == `OAG_OP_DEC) || (op == `OAG_OP_RC_SUB) ||
                     (op == `OAG_OP_IDX_SUB);
    end
  endfunction

  function op_reverses;
    input [2:0] op;
    begin
      op_reverses = (op == `OAG_OP_RC_SUB) || (op == `OAG_OP_RC_ADD);
    end
  endfunction

  function op_unit_step;
    input [2:0] op;
    begin
      op_unit_step = (op == `OAG_OP_DEC) || (op == `OAG_OP_INC);
    end
  endfunction

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  reg  [5:0]             state_reg;
  reg  [5:0]             state_next;
  reg  [`OAG_WORD_W-1:0] aux_pointer_reg [0:`OAG_AUX_COUNT-1];
  reg  [`OAG_WORD_W-1:0] index_reg;
  reg  [2:0]             pointer_select_reg;
  reg  [2:0]             pointer_select_backup_reg;
  reg  [`OAG_WORD_W-1:0] data_addr_reg;
  reg                    data_rd_reg;
  reg                    data_wr_reg;
  reg  [`OAG_WORD_W-1:0] data_wdata_reg;
  reg  [`OAG_WORD_W-1:0] prog_addr_reg;
  reg                    prog_rd_reg;
  reg  [`OAG_WORD_W-1:0] pc_reg;
  reg  [`OAG_WORD_W-1:0] prefetch_counter_reg;
  reg  [`OAG_WORD_W-1:0] micro_call_stack_reg;
  reg  [`OAG_ACC_W-1:0]  accumulator_reg;
  reg  [`OAG_WORD_W-1:0] dest_addr_reg;
  reg  [`OAG_RPT_W-1:0]  repeat_left_reg;
  reg                    acc_pending_reg;

  // ----------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------
  wire                   take;
  wire                   is_mem;
  wire                   is_ind;
  wire [2:0]             ptr_op;
  wire                   ptr_we;
  wire                   psel_we;
  wire [`OAG_WORD_W-1:0] cur_ptr;
  wire [`OAG_WORD_W-1:0] ptr_new;
  wire [`OAG_WORD_W-1:0] step_value;
  wire [`OAG_WORD_W-1:0] direct_addr;
  wire [`OAG_ACC_W-1:0]  short_imm;
  wire [`OAG_ACC_W-1:0]  long_imm;
  wire [`OAG_ACC_W-1:0]  mem_shifted;

  assign instr_ready = (state_reg == S_IDLE);
  assign take        = instr_valid && instr_ready;
  assign is_mem      = (instr_kind == `OAG_KIND_MEM);
  assign is_ind      = is_mem && instr_word[`OAG_MODE_BIT];
  assign ptr_op      = instr_word[`OAG_OP_HI:`OAG_OP_LO];
  assign ptr_we      = take && is_ind && op_modifies(ptr_op);
  assign psel_we     = take && is_ind && instr_word[`OAG_CHG_BIT];
  assign cur_ptr     = aux_pointer_reg[pointer_select_reg];
  // Plus or minus one reuses the index adder with a unit step
  assign step_value  = op_unit_step(ptr_op) ? `OAG_STEP_ONE
                                            : index_reg;
  assign direct_addr = {data_page,
                        instr_word[`OAG_DMA_HI:`OAG_DMA_LO]};
  assign short_imm   = {{(`OAG_ACC_W-8){1'b0}},
                        instr_word[`OAG_SIMM_HI:`OAG_SIMM_LO]};
  assign long_imm    = {{(`OAG_ACC_W-`OAG_WORD_W){1'b0}},
                        second_word};
  assign mem_shifted = {{(`OAG_ACC_W-`OAG_WORD_W-`OAG_ADD_SHIFT){1'b0}},
                        mem_rdata, {`OAG_ADD_SHIFT{1'b0}}};

  oag_rc_alu u_rc_alu
  (
    .operand_a     (cur_ptr),
    .operand_b     (step_value),
    .subtract      (op_subtracts(ptr_op)),
    .carry_reverse (op_reverses(ptr_op)),
    .result        (ptr_new)
  );

  // ----------------------------------------------------------------
  // Pointer file
  // ----------------------------------------------------------------
  // An instruction update wins over a load port write to the same
  // pointer, since the load port stands for a later instruction.
  genvar gi;
  generate
    for (gi = 0; gi < `OAG_AUX_COUNT; gi = gi + 1)
    begin : g_aux
      localparam [31:0] IDX = gi;
      always @(posedge sys_clk)
      begin
        if (!rstn)
          aux_pointer_reg[IDX] <= `OAG_AUX_RESET;
        else if (ptr_we && ({29'h0, pointer_select_reg} == IDX))
          aux_pointer_reg[IDX] <= ptr_new;
        else if (aux_load && ({29'h0, aux_load_sel} == IDX))
          aux_pointer_reg[IDX] <= aux_load_data;
      end
    end
  endgenerate

  always @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      index_reg                 <= `OAG_INDEX_RESET;
      pointer_select_reg        <= `OAG_PSEL_RESET;
      pointer_select_backup_reg <= `OAG_PSEL_RESET;
    end
    else
    begin
      if (index_load)
        index_reg <= index_load_data;
      if (psel_we)
      begin
        pointer_select_backup_reg <= pointer_select_reg;
        pointer_select_reg        <= instr_word[`OAG_NAR_HI:`OAG_NAR_LO];
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE:
      begin
        if (take && is_mem)
          state_next = S_MWAIT;
        else if (take && (instr_kind == `OAG_KIND_DUAL))
          state_next = S_FETCH;
      end
      S_MWAIT:
        state_next = acc_pending_reg ? S_MACC : S_IDLE;
      S_MACC:
        state_next = S_IDLE;
      S_FETCH:
        state_next = S_PWAIT;
      S_PWAIT:
        state_next = S_WRITE;
      S_WRITE:
        state_next = (repeat_left_reg != 8'h00) ? S_FETCH : S_IDLE;
      default:
        state_next = S_IDLE;
    endcase
  end

  always @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      state_reg            <= S_IDLE;
      data_addr_reg        <= 16'h0000;
      data_rd_reg          <= 1'b0;
      data_wr_reg          <= 1'b0;
      data_wdata_reg       <= 16'h0000;
      prog_addr_reg        <= 16'h0000;
      prog_rd_reg          <= 1'b0;
      pc_reg               <= `OAG_PC_RESET;
      prefetch_counter_reg <= `OAG_PC_RESET;
      micro_call_stack_reg <= `OAG_PC_RESET;
      accumulator_reg      <= `OAG_ACC_RESET;
      dest_addr_reg        <= 16'h0000;
      repeat_left_reg      <= 8'h00;
      acc_pending_reg      <= 1'b0;
    end
    else
    begin
      state_reg   <= state_next;
      data_rd_reg <= 1'b0;
      data_wr_reg <= 1'b0;
      prog_rd_reg <= 1'b0;
      case (state_reg)
        S_IDLE:
        begin
          if (take)
          begin
            case (instr_kind)
              `OAG_KIND_MEM:
              begin
                // Address is the pointer before its update
                data_addr_reg   <= is_ind ? cur_ptr : direct_addr;
                data_rd_reg     <= 1'b1;
                acc_pending_reg <= (instr_word[`OAG_OPC_HI:`OAG_OPC_LO] ==
                                    `OAG_OPC_ADD_SH8);
                pc_reg               <= pc_reg + `OAG_STEP_ONE;
                prefetch_counter_reg <= pc_reg + `OAG_STEP_ONE;
              end
              `OAG_KIND_SHORT:
              begin
                accumulator_reg      <= accumulator_reg + short_imm;
                pc_reg               <= pc_reg + `OAG_STEP_ONE;
                prefetch_counter_reg <= pc_reg + `OAG_STEP_ONE;
              end
              `OAG_KIND_LONG:
              begin
                accumulator_reg      <= accumulator_reg + long_imm;
                pc_reg               <= pc_reg + `OAG_STEP_TWO;
                prefetch_counter_reg <= pc_reg + `OAG_STEP_TWO;
              end
              default:
              begin
                micro_call_stack_reg <= prefetch_counter_reg;
                prefetch_counter_reg <= second_word;
                dest_addr_reg        <= direct_addr;
                repeat_left_reg      <= repeat_count;
              end
            endcase
          end
        end
        S_MWAIT:
        begin
          if (!acc_pending_reg)
            acc_pending_reg <= 1'b0;
        end
        S_MACC:
        begin
          accumulator_reg <= accumulator_reg + mem_shifted;
          acc_pending_reg <= 1'b0;
        end
        S_FETCH:
        begin
          prog_addr_reg <= prefetch_counter_reg;
          prog_rd_reg   <= 1'b1;
        end
        S_PWAIT:
        begin
          prog_rd_reg <= 1'b0;
        end
        S_WRITE:
        begin
          data_addr_reg  <= dest_addr_reg;
          data_wdata_reg <= prog_rdata;
          data_wr_reg    <= 1'b1;
          if (repeat_left_reg != 8'h00)
          begin
            repeat_left_reg      <= repeat_left_reg - 8'h01;
            prefetch_counter_reg <= prefetch_counter_reg +
                                    `OAG_STEP_ONE;
          end
          else
          begin
            prefetch_counter_reg <= micro_call_stack_reg;
            pc_reg               <= pc_reg + `OAG_STEP_TWO;
          end
        end
        default:
        begin
          acc_pending_reg <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // The repeated move keeps one destination; a walking destination
  // needs an indirect operand, which this path does not offer.
  assign data_addr             = data_addr_reg;
  assign data_rd               = data_rd_reg;
  assign data_wr               = data_wr_reg;
  assign data_wdata            = data_wdata_reg;
  assign program_addr_bus      = prog_addr_reg;
  assign prog_rd               = prog_rd_reg;
  assign program_counter       = pc_reg;
  assign prefetch_counter      = prefetch_counter_reg;
  assign micro_call_stack      = micro_call_stack_reg;
  assign accumulator           = accumulator_reg;
  assign pointer_select        = pointer_select_reg;
  assign pointer_select_backup = pointer_select_backup_reg;
  assign index_value           = index_reg;

endmodule // oag_core

/* File: verilog/oag_consts.vh */
`ifndef OAG_CONSTS_VH
`define OAG_CONSTS_VH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define OAG_WORD_W        16
`define OAG_ACC_W         32
`define OAG_AUX_COUNT     8
`define OAG_PAGE_W        9
`define OAG_RPT_W         8

// ----------------------------------------------------------------
// Instruction word fields
// ----------------------------------------------------------------
`define OAG_OPC_HI        15
`define OAG_OPC_LO        8
`define OAG_MODE_BIT      7
`define OAG_OP_HI         6
`define OAG_OP_LO         4
`define OAG_CHG_BIT       3
`define OAG_NAR_HI        2
`define OAG_NAR_LO        0
`define OAG_DMA_HI        6
`define OAG_DMA_LO        0
`define OAG_SIMM_HI       7
`define OAG_SIMM_LO       0

// Opcode of the accumulate-with-left-shift-by-8 instruction
`define OAG_OPC_ADD_SH8   8'h28
`define OAG_ADD_SHIFT     8

// ----------------------------------------------------------------
// Pointer arithmetic field codes (bits 6..4)
// ----------------------------------------------------------------
`define OAG_OP_NONE       3'h0
`define OAG_OP_DEC        3'h1
`define OAG_OP_INC        3'h2
`define OAG_OP_RSVD       3'h3
`define OAG_OP_RC_SUB     3'h4
`define OAG_OP_IDX_SUB    3'h5
`define OAG_OP_IDX_ADD    3'h6
`define OAG_OP_RC_ADD     3'h7

// ----------------------------------------------------------------
// Instruction kinds presented by the fetch stage
// ----------------------------------------------------------------
`define OAG_KIND_MEM      2'h0
`define OAG_KIND_SHORT    2'h1
`define OAG_KIND_LONG     2'h2
`define OAG_KIND_DUAL     2'h3

// ----------------------------------------------------------------
// Reset values and steps
// ----------------------------------------------------------------
`define OAG_AUX_RESET     16'h0000
`define OAG_INDEX_RESET   16'h0000
`define OAG_PSEL_RESET    3'h0
`define OAG_PC_RESET      16'h0000
`define OAG_ACC_RESET     32'h00000000
`define OAG_STEP_ONE      16'h0001
`define OAG_STEP_TWO      16'h0002

`endif

/* File: verilog/oag_rc_alu.v */
`timescale 1ns/1ns
`include "oag_consts.vh"

module oag_rc_alu
(
  input  wire [`OAG_WORD_W-1:0] operand_a,
  input  wire [`OAG_WORD_W-1:0] operand_b,
  input  wire                   subtract,
  input  wire                   carry_reverse,
  output wire [`OAG_WORD_W-1:0] result
);

  // ----------------------------------------------------------------
  // Bit mirroring
  // ----------------------------------------------------------------
  // Mirroring both operands and the sum turns an ordinary adder into
  // one whose carry runs from the top bit downward, so one adder
  // serves both the plain and the bit-reversed modes.
  wire [`OAG_WORD_W-1:0] a_rev;
  wire [`OAG_WORD_W-1:0] b_rev;
  wire [`OAG_WORD_W-1:0] s_rev;
  wire [`OAG_WORD_W-1:0] a_sel;
  wire [`OAG_WORD_W-1:0] b_sel;
  wire [`OAG_WORD_W-1:0] sum;

  genvar gi;
  generate
    for (gi = 0; gi < `OAG_WORD_W; gi = gi + 1)
    begin : g_mirror
      assign a_rev[gi] = operand_a[`OAG_WORD_W-1-gi];
      assign b_rev[gi] = operand_b[`OAG_WORD_W-1-gi];
      assign s_rev[gi] = sum[`OAG_WORD_W-1-gi];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Adder
  // ----------------------------------------------------------------
  assign a_sel  = carry_reverse ? a_rev : operand_a;
  assign b_sel  = carry_reverse ? b_rev : operand_b;
  assign sum    = subtract ? (a_sel - b_sel) : (a_sel + b_sel);
  assign result = carry_reverse ? s_rev : sum;

endmodule // oag_rc_alu

/* File: bench/oag_mem_model.sv */
`timescale 1ns/1ns

module oag_mem_model
(
  input  wire        sys_clk,
  input  wire        data_rd,
  input  wire [15:0] data_addr,
  input  wire        prog_rd,
  input  wire [15:0] program_addr_bus,
  output reg  [15:0] mem_rdata,
  output reg  [15:0] prog_rdata
);
  // ------
  // Bus answers
  // ------
  initial
  begin
    mem_rdata = 16'h0000;
    prog_rdata = 16'h0000;
  end

  // Outside the valid cycle the lines keep toggling, so a sample one cycle
  // late meets the complement, though two cycles late the word is back
  always @(posedge sys_clk)
  begin
    if (data_rd)
      mem_rdata <= data_addr ^ 16'hA5C3;
    else
      mem_rdata <= ~mem_rdata;
    if (prog_rd)
      prog_rdata <= program_addr_bus ^ 16'h3C5A;
    else
      prog_rdata <= ~prog_rdata;
  end
endmodule // oag_mem_model

/* File: bench/oag_assertions.sv */
`timescale 1ns/1ns
`include "oag_consts.vh"

module oag_assertions
(
  input wire        sys_clk,
  input wire        rstn,
  input wire        instr_valid,
  input wire [1:0]  instr_kind,
  input wire [15:0] instr_word,
  input wire [15:0] second_word,
  input wire [7:0]  repeat_count,
  input wire [8:0]  data_page,
  input wire [15:0] mem_rdata,
  input wire [15:0] prog_rdata,
  input wire        instr_ready,
  input wire [15:0] data_addr,
  input wire        data_rd,
  input wire        data_wr,
  input wire [15:0] data_wdata,
  input wire [15:0] program_addr_bus,
  input wire        prog_rd,
  input wire [15:0] program_counter,
  input wire [15:0] prefetch_counter,
  input wire [15:0] micro_call_stack,
  input wire [31:0] accumulator,
  input wire [2:0]  pointer_select,
  input wire [2:0]  pointer_select_backup
);
  // ------
  // Checks
  // ------
  wire tk = instr_valid && instr_ready;
  wire tk_mem = tk && instr_kind == `OAG_KIND_MEM;
  wire tk_ind = tk_mem && instr_word[7];
  wire tk_dual = tk && instr_kind == `OAG_KIND_DUAL;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  a_ready_after_reset: assert property ($rose(rstn) |-> instr_ready)
    else $error("not ready after reset");
  a_mem_read_strobe: assert property (tk_mem |=> data_rd &&
    program_counter == $past(program_counter) + 16'h0001 ##1 !data_rd)
    else $error("memory read strobe wrong");
  a_direct_page_addr: assert property (tk_mem && !instr_word[7] |=>
    data_addr == {$past(data_page), $past(instr_word[6:0])})
    else $error("direct address wrong");
  a_accum_shift_eight: assert property (tk_mem &&
    instr_word[15:8] == `OAG_OPC_ADD_SH8 |-> ##3 accumulator ==
    $past(accumulator, 3) + {8'h00, $past(mem_rdata), 8'h00})
    else $error("shifted accumulate wrong");
  a_pointer_select_reload: assert property (tk_ind && instr_word[3] |=>
    pointer_select == $past(instr_word[2:0]) &&
    pointer_select_backup == $past(pointer_select))
    else $error("pointer select reload wrong");
  a_short_imm_add: assert property (tk && instr_kind == `OAG_KIND_SHORT |=>
    accumulator == $past(accumulator) + {24'h000000, $past(instr_word[7:0])})
    else $error("short add wrong");
  a_long_imm_add: assert property (tk && instr_kind == `OAG_KIND_LONG |=>
    accumulator == $past(accumulator) + {16'h0000, $past(second_word)} &&
    program_counter == $past(program_counter) + 16'h0002)
    else $error("long add wrong");
  a_dual_push_load: assert property (tk_dual |=>
    micro_call_stack == $past(prefetch_counter) &&
    prefetch_counter == $past(second_word) ##0 !instr_ready [*3])
    else $error("dual push wrong");
  a_dual_prog_fetch: assert property (tk_dual |-> ##2 prog_rd &&
    program_addr_bus == $past(second_word, 2))
    else $error("program fetch wrong");
  a_dual_finish_pop: assert property (tk_dual && repeat_count == 8'h00
    |-> ##4 data_wr && instr_ready && data_wdata == $past(prog_rdata) &&
    data_addr == {$past(data_page, 4), $past(instr_word[6:0], 4)} &&
    prefetch_counter == $past(prefetch_counter, 4) &&
    program_counter == $past(program_counter, 4) + 16'h0002)
    else $error("dual finish wrong");

  c_dual_repeat: cover property (tk_dual && repeat_count != 8'h00);
  c_select_change: cover property (tk_ind && instr_word[3]);
  c_rev_add: cover property (tk_ind && instr_word[6:4] == `OAG_OP_RC_ADD);
endmodule // oag_assertions

bind oag_core oag_assertions oag_assertions_inst (.*);

/* File: bench/oag_core_test.sv */
`timescale 1ns/1ns
`include "oag_consts.vh"

module oag_core_test;
  reg         sys_clk;
  reg         rstn;
  reg         instr_valid;
  reg  [1:0]  instr_kind;
  reg  [15:0] instr_word;
  reg  [15:0] second_word;
  reg  [7:0]  repeat_count;
  reg  [8:0]  data_page;
  reg         aux_load;
  reg  [2:0]  aux_load_sel;
  reg  [15:0] aux_load_data;
  reg         index_load;
  reg  [15:0] index_load_data;
  wire [15:0] mem_rdata;
  wire [15:0] prog_rdata;
  wire        instr_ready;
  wire [15:0] data_addr;
  wire        data_rd;
  wire        data_wr;
  wire [15:0] data_wdata;
  wire [15:0] program_addr_bus;
  wire        prog_rd;
  wire [15:0] program_counter;
  wire [15:0] prefetch_counter;
  wire [15:0] micro_call_stack;
  wire [31:0] accumulator;
  wire [2:0]  pointer_select;
  wire [2:0]  pointer_select_backup;
  wire [15:0] index_value;
  integer     fail_count;
  integer     checks;
  integer     cyc;
  reg  [31:0] exp_acc;
  reg  [15:0] exp_pc;

  oag_core oag_core_inst (.*);
  oag_mem_model oag_mem_model_inst (.*);

  // ------
  // Helpers
  // ------
  task automatic chk(input [31:0] got, input [31:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp)
      begin
        fail_count = fail_count + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  task automatic end_sim;
    begin
      if (fail_count == 0 && checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask

  task automatic step;
    begin
      @(posedge sys_clk);
      #1;
    end
  endtask

  // Bounded, so a stuck busy state shows up as a mismatch
  task automatic wait_ready;
    integer n;
    begin
      n = 0;
      while (instr_ready !== 1'b1 && n < 40)
      begin
        step;
        n = n + 1;
      end
      chk(instr_ready, 1'b1);
    end
  endtask

  task automatic issue(input [1:0] k, input [15:0] w, input [15:0] s,
                       input [7:0] r, input hold);
    begin
      wait_ready;
      instr_valid = 1'b1;
      instr_kind = k;
      instr_word = w;
      second_word = s;
      repeat_count = r;
      step;
      if (!hold)
        instr_valid = 1'b0;
      exp_pc = exp_pc + (k[1] ? 16'h0002 : 16'h0001);
    end
  endtask

  task automatic mem_op(input [15:0] w, input [15:0] a);
    begin
      issue(`OAG_KIND_MEM, w, 16'h0000, 8'h00, 1'b0);
      chk(data_rd, 1'b1);
      chk(data_addr, a);
      if (w[15:8] == 8'h28)
        exp_acc = exp_acc + {8'h00, a ^ 16'hA5C3, 8'h00};
      wait_ready;
      chk(accumulator, exp_acc);
    end
  endtask

  task automatic load_aux(input [2:0] sel, input [15:0] d);
    begin
      aux_load = 1'b1;
      aux_load_sel = sel;
      aux_load_data = d;
      step;
      aux_load = 1'b0;
    end
  endtask

  task automatic load_idx(input [15:0] d);
    begin
      index_load = 1'b1;
      index_load_data = d;
      step;
      index_load = 1'b0;
      chk(index_value, d);
    end
  endtask

  // ------
  // Scenarios
  // ------
  task automatic t_steps;
    begin
      load_aux(3'h0, 16'h0100);
      mem_op(16'h28A0, 16'h0100);
      mem_op(16'h28A0, 16'h0101);
      load_aux(3'h3, 16'h0300);
      mem_op(16'h28AB, 16'h0102);
      chk(pointer_select, 3'h3);
      chk(pointer_select_backup, 3'h0);
      mem_op(16'h28A0, 16'h0300);
      load_idx(16'h0010);
      mem_op(16'h28E0, 16'h0301);
      mem_op(16'h28D0, 16'h0311);
      mem_op(16'h2880, 16'h0301);
    end
  endtask

  task automatic t_bitrev;
    integer i;
    reg [3:0] k;
    begin
      load_aux(3'h3, 16'h0060);
      load_idx(16'h0008);
      for (i = 0; i < 16; i = i + 1)
      begin
        k = i[3:0];
        mem_op(16'h28F0, {12'h006, k[0], k[1], k[2], k[3]});
      end
      mem_op(16'h28C0, 16'h0060);
      mem_op(16'h28C0, 16'h006F);
      mem_op(16'h2890, 16'h0067);
      mem_op(16'h28B0, 16'h0066);
      mem_op(16'h2880, 16'h0066);
      data_page = 9'h1A5;
      mem_op(16'h2805, 16'hD285);
      mem_op(16'h1005, 16'hD285);
    end
  endtask

  task automatic t_imm;
    begin
      issue(`OAG_KIND_SHORT, 16'hB9FE, 16'h0000, 8'h00, 1'b1);
      exp_acc = exp_acc + 32'h000000FE;
      issue(`OAG_KIND_LONG, 16'h0000, 16'h1234, 8'h00, 1'b0);
      exp_acc = exp_acc + 32'h00001234;
      chk(accumulator, exp_acc);
      chk(program_counter, exp_pc);
      // Let an edge pass so the next request does not re-raise valid
      step;
    end
  endtask

  task automatic t_dual(input [7:0] r);
    integer n;
    integer np;
    integer nw;
    reg [15:0] pc0;
    begin
      pc0 = exp_pc;
      data_page = 9'h004;
      np = 0;
      nw = 0;
      issue(`OAG_KIND_DUAL, 16'h3012, 16'h0400, r, 1'b0);
      chk(micro_call_stack, pc0);
      for (n = 0; n < 14; n = n + 1)
      begin
        if (prog_rd === 1'b1)
        begin
          chk(program_addr_bus, 16'h0400 + np);
          np = np + 1;
        end
        if (data_wr === 1'b1)
        begin
          chk(data_addr, 16'h0212);
          chk(data_wdata, (16'h0400 + nw) ^ 16'h3C5A);
          nw = nw + 1;
        end
        step;
      end
      chk(np, r + 1);
      chk(nw, r + 1);
      chk(prefetch_counter, pc0);
      chk(program_counter, exp_pc);
    end
  endtask

  task automatic t_reset;
    begin
      issue(`OAG_KIND_DUAL, 16'h3012, 16'h0400, 8'h03, 1'b0);
      rstn = 1'b0;
      step;
      rstn = 1'b1;
      chk(instr_ready, 1'b1);
      chk(accumulator, 32'h00000000);
      chk(pointer_select, 3'h0);
      exp_acc = 32'h00000000;
      exp_pc = 16'h0000;
      step;
      mem_op(16'h28A0, 16'h0000);
    end
  endtask

  // ------
  // Run
  // ------
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 3000)
    begin
      fail_count = fail_count + 1;
      end_sim;
    end
  end

  initial
  begin
    rstn = 1'b0;
    instr_valid = 1'b0;
    instr_kind = 2'h0;
    instr_word = 16'h0000;
    second_word = 16'h0000;
    repeat_count = 8'h00;
    data_page = 9'h000;
    aux_load = 1'b0;
    aux_load_sel = 3'h0;
    aux_load_data = 16'h0000;
    index_load = 1'b0;
    index_load_data = 16'h0000;
    fail_count = 0;
    checks = 0;
    cyc = 0;
    exp_acc = 32'h00000000;
    exp_pc = 16'h0000;
    repeat (5) @(posedge sys_clk);
    #1;
    rstn = 1'b1;
    step;
    t_steps;
    t_bitrev;
    t_dual(8'h00);
    t_imm;
    t_dual(8'h02);
    t_reset;
    end_sim;
  end
endmodule // oag_core_test
